// ===== verilog/bsa_pkg.sv
// ============================================================
// shared constants for the boolean, shift and test datapath
package bsa_pkg;

    // ============================================================
    // widths
    localparam int WORD_W = 36;
    localparam int EA_W   = 18;
    localparam int ACC_W  = 4;
    localparam int CNT_W  = 9;
    localparam int OP_W   = 4;

    // ============================================================
    // reset values
    localparam logic [WORD_W-1:0] WORD_RESET = 36'h000000000;
    localparam logic [EA_W-1:0]   EA_RESET   = 18'h00000;
    localparam logic [ACC_W-1:0]  ACC_RESET  = 4'h0;
    localparam logic [CNT_W-1:0]  CNT_RESET  = 9'h000;

    // ============================================================
    // shift count field: ea bit 17 is the sign, ea bits 7..0 the low part
    localparam int CNT_SIGN_POS = 17;
    localparam int CNT_LOW_W    = 8;

    // ============================================================
    // word bit positions, counted from the lsb
    localparam int SIGN_POS = 35;
    localparam int BIT1_POS = 34;
    localparam int BIT2_POS = 33;

    // ============================================================
    // pair partner of the last accumulator lives in memory
    localparam logic [ACC_W-1:0] LAST_ACC       = 4'hF;
    localparam logic [EA_W-1:0]  PAIR_MEM_ADDR  = 18'h00010;

    // ============================================================
    // command groups
    localparam logic [1:0] GRP_BOOL  = 2'h0;
    localparam logic [1:0] GRP_SHIFT = 2'h1;
    localparam logic [1:0] GRP_TEST  = 2'h2;

    // ============================================================
    // boolean operation codes: code bit {~mem,~acc} is the result bit
    localparam logic [OP_W-1:0] OP_SET_ZEROS                = 4'h0;
    localparam logic [OP_W-1:0] OP_NOR_BOTH_OPERANDS        = 4'h8;
    localparam logic [OP_W-1:0] OP_COMPLEMENT_MEMORY_OPERAND = 4'hC;
    localparam logic [OP_W-1:0] OP_NAND_BOTH_OPERANDS       = 4'hE;
    localparam logic [OP_W-1:0] OP_SET_ALL_ONES             = 4'hF;

    // ============================================================
    // boolean modes
    localparam logic [1:0] MODE_BASIC     = 2'h0;
    localparam logic [1:0] MODE_IMMEDIATE = 2'h1;
    localparam logic [1:0] MODE_MEMORY    = 2'h2;
    localparam logic [1:0] MODE_BOTH      = 2'h3;

    // ============================================================
    // shift kinds
    localparam logic [1:0] SHK_ARITHMETIC = 2'h0;
    localparam logic [1:0] SHK_CIRCULAR   = 2'h1;
    localparam logic [1:0] SHK_LOGICAL    = 2'h2;

    // ============================================================
    // test variants
    localparam logic [1:0] TV_PLAIN     = 2'h0;
    localparam logic [1:0] TV_INCREMENT = 2'h1;
    localparam logic [1:0] TV_DECREMENT = 2'h2;

    // ============================================================
    // skip and jump conditions
    localparam logic [2:0] CND_NEVER  = 3'h0;
    localparam logic [2:0] CND_LT     = 3'h1;
    localparam logic [2:0] CND_EQ     = 3'h2;
    localparam logic [2:0] CND_LE     = 3'h3;
    localparam logic [2:0] CND_ALWAYS = 3'h4;
    localparam logic [2:0] CND_GE     = 3'h5;
    localparam logic [2:0] CND_NE     = 3'h6;
    localparam logic [2:0] CND_GT     = 3'h7;

endpackage : bsa_pkg

// ===== verilog/bsa_shift_if.sv
`timescale 1ns/100ps
// ============================================================
// one shift step: controller supplies the word, step logic returns it moved
interface bsa_shift_if;
    logic [1:0]                 kind;
    logic                       pair;
    logic                       left;
    logic [bsa_pkg::WORD_W-1:0] hi;
    logic [bsa_pkg::WORD_W-1:0] lo;
    logic [bsa_pkg::WORD_W-1:0] hi_n;
    logic [bsa_pkg::WORD_W-1:0] lo_n;
    logic                       ovf;

    modport step (input kind, pair, left, hi, lo, output hi_n, lo_n, ovf);
    modport ctrl (output kind, pair, left, hi, lo, input hi_n, lo_n, ovf);
endinterface : bsa_shift_if

// ===== verilog/bsa_shift_step.sv
`timescale 1ns/100ps
// ============================================================
// single-place shifter for single words and accumulator pairs
module bsa_shift_step (
    // step port
    bsa_shift_if.step sh
);
    logic [2*bsa_pkg::WORD_W-1:0] dbl;

    always_comb begin
        dbl    = {sh.hi, sh.lo};
        sh.ovf = 1'b0;
        case (sh.kind)
            bsa_pkg::SHK_ARITHMETIC: begin
                if (sh.left) begin
                    // sign stays; bit 1 of the low word crosses into the high word
                    dbl[71:36] = {sh.hi[35], sh.hi[33:0], sh.pair & sh.lo[34]};
                    if (sh.pair) begin
                        dbl[35:0] = {sh.hi[35], sh.lo[33:0], 1'b0};
                    end
                    sh.ovf = sh.hi[35] ^ sh.hi[33];
                end else begin
                    dbl[71:36] = {sh.hi[35], sh.hi[35], sh.hi[34:1]};
                    if (sh.pair) begin
                        dbl[35:0] = {sh.hi[35], sh.hi[0], sh.lo[34:1]};
                    end
                end
            end
            bsa_pkg::SHK_CIRCULAR: begin
                if (sh.pair) begin
                    dbl = sh.left ? {sh.hi[34:0], sh.lo, sh.hi[35]}
                                  : {sh.lo[0], sh.hi, sh.lo[35:1]};
                end else begin
                    dbl[71:36] = sh.left ? {sh.hi[34:0], sh.hi[35]}
                                         : {sh.hi[0], sh.hi[35:1]};
                end
            end
            bsa_pkg::SHK_LOGICAL: begin
                if (sh.pair) begin
                    dbl = sh.left ? {sh.hi[34:0], sh.lo, 1'b0}
                                  : {1'b0, sh.hi, sh.lo[35:1]};
                end else begin
                    dbl[71:36] = sh.left ? {sh.hi[34:0], 1'b0}
                                         : {1'b0, sh.hi[35:1]};
                end
            end
            default: begin
                dbl = {sh.hi, sh.lo};
            end
        endcase
        sh.hi_n = dbl[71:36];
        sh.lo_n = dbl[35:0];
    end

endmodule : bsa_shift_step

// ===== verilog/bsa_alu.sv
`timescale 1ns/100ps
// What this block does
// - sixteen boolean functions, accumulator with memory
// - each result bit uses same-position bits
// - complement memory ignores the accumulator
// - nor both: one where both zero
// - nand both: or of inverted operands
// - all ones regardless of operands
// - basic mode: memory operand, result to accumulator
// - immediate mode: address is operand, accumulator
// - memory mode: result to memory only
// - both mode: result to accumulator and memory
// - arithmetic shift keeps sign, drops bit 1 going left, bit 35 going right
// - overflow when bits 0,2 differ on any arithmetic left step
// - rotate reinserts bits at other end
// - logical shift fills with zeros
// - nine-bit signed count from address bits
// - pair is accumulator and next; 17 pairs memory
// - arithmetic pair is one 71-bit value
// - low word sign copies high sign
// - right pair shift skips low sign bit
// - left pair shift crosses bit 1 to 35
// - pair rotate and logical span both words
// - jump loads pc with address when true
// - memory skip skips next when true
// - plain variants leave the word unchanged
// - increment adds one, decrement subtracts one
// - eight conditions never through greater than
module bsa_alu (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         arst_n,
    // command from the sequencer
    input  wire logic                         start,
    input  wire logic [1:0]                   group,
    input  wire logic [bsa_pkg::OP_W-1:0]     bool_op,
    input  wire logic [1:0]                   bool_mode,
    input  wire logic [1:0]                   shift_kind,
    input  wire logic                         shift_pair,
    input  wire logic [1:0]                   test_variant,
    input  wire logic                         test_on_mem,
    input  wire logic [2:0]                   cond,
    input  wire logic [bsa_pkg::ACC_W-1:0]    acc_sel,
    input  wire logic [bsa_pkg::EA_W-1:0]     ea,
    // operands fetched by the sequencer
    input  wire logic [bsa_pkg::WORD_W-1:0]   acc_data,
    input  wire logic [bsa_pkg::WORD_W-1:0]   pair_data,
    input  wire logic [bsa_pkg::WORD_W-1:0]   mem_data,
    // status
    output logic                              busy,
    output logic                              done,
    output logic                              overflow_set,
    // accumulator write-back
    output logic                              acc_we,
    output logic [bsa_pkg::ACC_W-1:0]         acc_waddr,
    output logic [bsa_pkg::WORD_W-1:0]        acc_wdata,
    output logic                              pair_we,
    output logic [bsa_pkg::ACC_W-1:0]         pair_waddr,
    output logic [bsa_pkg::WORD_W-1:0]        pair_wdata,
    // memory write-back
    output logic                              mem_we,
    output logic [bsa_pkg::EA_W-1:0]          mem_waddr,
    output logic [bsa_pkg::WORD_W-1:0]        mem_wdata,
    // program flow
    output logic                              pc_load,
    output logic [bsa_pkg::EA_W-1:0]          pc_value,
    output logic                              skip
);

    // ============================================================
    // functions
    function automatic logic [bsa_pkg::WORD_W-1:0] bool_fn(
        input logic [bsa_pkg::OP_W-1:0]   op,
        input logic [bsa_pkg::WORD_W-1:0] a,
        input logic [bsa_pkg::WORD_W-1:0] m
    );
        logic [bsa_pkg::WORD_W-1:0] r;
        r = '0;
        // the op code is the truth table itself, one column per bit pair
        for (int i = 0; i < bsa_pkg::WORD_W; i++) begin
            r[i] = op[{~m[i], ~a[i]}];
        end
        return r;
    endfunction : bool_fn

    function automatic logic cond_fn(
        input logic [2:0]                 c,
        input logic [bsa_pkg::WORD_W-1:0] v
    );
        logic neg;
        logic zero;
        logic r;
        neg  = v[bsa_pkg::SIGN_POS];
        zero = (v == bsa_pkg::WORD_RESET);
        case (c)
            bsa_pkg::CND_NEVER:  r = 1'b0;
            bsa_pkg::CND_LT:     r = neg;
            bsa_pkg::CND_EQ:     r = zero;
            bsa_pkg::CND_LE:     r = neg | zero;
            bsa_pkg::CND_ALWAYS: r = 1'b1;
            bsa_pkg::CND_GE:     r = ~neg;
            bsa_pkg::CND_NE:     r = ~zero;
            bsa_pkg::CND_GT:     r = ~neg & ~zero;
            default:             r = 1'b0;
        endcase
        return r;
    endfunction : cond_fn

    // ============================================================
    // state
    typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} bsa_state_e;

    bsa_state_e                  state;
    logic [bsa_pkg::WORD_W-1:0]  hi;
    logic [bsa_pkg::WORD_W-1:0]  lo;
    logic [bsa_pkg::CNT_W-1:0]   cnt;
    logic                        sh_left;
    logic [1:0]                  sh_kind;
    logic                        sh_pair;
    logic                        ovf_seen;
    logic [bsa_pkg::ACC_W-1:0]   sh_acc;

    // ============================================================
    // command decode
    logic                        fire;
    logic                        finish;
    logic [bsa_pkg::WORD_W-1:0]  bool_operand;
    logic [bsa_pkg::WORD_W-1:0]  bool_res;
    logic [bsa_pkg::WORD_W-1:0]  test_src;
    logic [bsa_pkg::WORD_W-1:0]  test_val;
    logic                        test_met;
    logic                        test_mod;
    logic [bsa_pkg::CNT_W-1:0]   cnt_field;
    logic [bsa_pkg::CNT_W-1:0]   cnt_mag;

    assign fire   = (state == ST_IDLE) && start;
    assign finish = (state == ST_SHIFT) && (cnt == bsa_pkg::CNT_RESET);

    // immediate mode takes the address itself, so no memory word is used
    assign bool_operand = (bool_mode == bsa_pkg::MODE_IMMEDIATE)
                        ? {{(bsa_pkg::WORD_W-bsa_pkg::EA_W){1'b0}}, ea}
                        : mem_data;
    assign bool_res = bool_fn(bool_op, acc_data, bool_operand);

    assign test_src = test_on_mem ? mem_data : acc_data;
    always_comb begin
        case (test_variant)
            bsa_pkg::TV_INCREMENT: test_val = test_src + 36'h000000001;
            bsa_pkg::TV_DECREMENT: test_val = test_src - 36'h000000001;
            default:               test_val = test_src;
        endcase
    end
    assign test_met = cond_fn(cond, test_val);
    // only increment and decrement write back; the spare variant acts as plain
    assign test_mod = (test_variant == bsa_pkg::TV_INCREMENT)
                    || (test_variant == bsa_pkg::TV_DECREMENT);

    assign cnt_field = {ea[bsa_pkg::CNT_SIGN_POS], ea[bsa_pkg::CNT_LOW_W-1:0]};
    assign cnt_mag   = cnt_field[bsa_pkg::CNT_W-1] ? (~cnt_field + 9'h001) : cnt_field;

    // ============================================================
    // shift step
    bsa_shift_if sif ();

    assign sif.kind = sh_kind;
    assign sif.pair = sh_pair;
    assign sif.left = sh_left;
    assign sif.hi   = hi;
    assign sif.lo   = lo;

    bsa_shift_step u_step (
        .sh (sif.step)
    );

    // ============================================================
    // sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE:  if (fire && group == bsa_pkg::GRP_SHIFT) state <= ST_SHIFT;
                ST_SHIFT: if (finish) state <= ST_IDLE;
                default:  state <= ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // shift datapath, one place per clock so overflow is seen per step
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hi       <= bsa_pkg::WORD_RESET;
            lo       <= bsa_pkg::WORD_RESET;
            cnt      <= bsa_pkg::CNT_RESET;
            sh_left  <= 1'b0;
            sh_kind  <= bsa_pkg::SHK_ARITHMETIC;
            sh_pair  <= 1'b0;
            ovf_seen <= 1'b0;
            sh_acc   <= bsa_pkg::ACC_RESET;
        end else if (fire && group == bsa_pkg::GRP_SHIFT) begin
            hi       <= acc_data;
            lo       <= pair_data;
            cnt      <= cnt_mag;
            sh_left  <= ~cnt_field[bsa_pkg::CNT_W-1];
            sh_kind  <= shift_kind;
            sh_pair  <= shift_pair;
            ovf_seen <= 1'b0;
            sh_acc   <= acc_sel;
        end else if (state == ST_SHIFT && !finish) begin
            hi       <= sif.hi_n;
            lo       <= sif.lo_n;
            cnt      <= cnt - 9'h001;
            ovf_seen <= ovf_seen | (sif.ovf & (sh_kind == bsa_pkg::SHK_ARITHMETIC));
        end
    end

    // ============================================================
    // results: all strobes are single-cycle pulses
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy         <= 1'b0;
            done         <= 1'b0;
            overflow_set <= 1'b0;
            acc_we       <= 1'b0;
            acc_waddr    <= bsa_pkg::ACC_RESET;
            acc_wdata    <= bsa_pkg::WORD_RESET;
            pair_we      <= 1'b0;
            pair_waddr   <= bsa_pkg::ACC_RESET;
            pair_wdata   <= bsa_pkg::WORD_RESET;
            mem_we       <= 1'b0;
            mem_waddr    <= bsa_pkg::EA_RESET;
            mem_wdata    <= bsa_pkg::WORD_RESET;
            pc_load      <= 1'b0;
            pc_value     <= bsa_pkg::EA_RESET;
            skip         <= 1'b0;
        end else begin
            done         <= 1'b0;
            overflow_set <= 1'b0;
            acc_we       <= 1'b0;
            pair_we      <= 1'b0;
            mem_we       <= 1'b0;
            pc_load      <= 1'b0;
            skip         <= 1'b0;
            busy         <= (fire && group == bsa_pkg::GRP_SHIFT) || (state == ST_SHIFT && !finish);
            if (fire && group == bsa_pkg::GRP_BOOL) begin
                done      <= 1'b1;
                acc_waddr <= acc_sel;
                acc_wdata <= bool_res;
                mem_waddr <= ea;
                mem_wdata <= bool_res;
                case (bool_mode)
                    bsa_pkg::MODE_MEMORY: mem_we <= 1'b1;
                    bsa_pkg::MODE_BOTH: begin
                        acc_we <= 1'b1;
                        mem_we <= 1'b1;
                    end
                    default: acc_we <= 1'b1;
                endcase
            end else if (fire && group == bsa_pkg::GRP_TEST) begin
                done      <= 1'b1;
                acc_waddr <= acc_sel;
                acc_wdata <= test_val;
                mem_waddr <= ea;
                mem_wdata <= test_val;
                if (test_on_mem) begin
                    mem_we <= test_mod;
                    skip   <= test_met;
                end else begin
                    acc_we   <= test_mod;
                    pc_load  <= test_met;
                    pc_value <= ea;
                end
            end else if (finish) begin
                done         <= 1'b1;
                overflow_set <= ovf_seen;
                acc_we       <= 1'b1;
                acc_waddr    <= sh_acc;
                acc_wdata    <= hi;
                if (sh_pair) begin
                    // arithmetic pair: low sign always mirrors the high sign
                    if (sh_kind == bsa_pkg::SHK_ARITHMETIC) begin
                        pair_wdata <= {hi[bsa_pkg::SIGN_POS], lo[bsa_pkg::BIT1_POS:0]};
                        mem_wdata  <= {hi[bsa_pkg::SIGN_POS], lo[bsa_pkg::BIT1_POS:0]};
                    end else begin
                        pair_wdata <= lo;
                        mem_wdata  <= lo;
                    end
                    if (sh_acc == bsa_pkg::LAST_ACC) begin
                        mem_we    <= 1'b1;
                        mem_waddr <= bsa_pkg::PAIR_MEM_ADDR;
                    end else begin
                        pair_we    <= 1'b1;
                        pair_waddr <= sh_acc + 4'h1;
                    end
                end
            end
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic fire_bool;
    logic fire_test;
    logic fire_shift;
    logic fin_arith_pair;

    assign fire_bool  = fire && group == bsa_pkg::GRP_BOOL;
    assign fire_test  = fire && group == bsa_pkg::GRP_TEST;
    assign fire_shift = fire && group == bsa_pkg::GRP_SHIFT;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fin_arith_pair <= 1'b0;
        end else begin
            fin_arith_pair <= finish && sh_pair && sh_kind == bsa_pkg::SHK_ARITHMETIC;
        end
    end

    all_ones_a: assert property (
        fire_bool && bool_op == bsa_pkg::OP_SET_ALL_ONES && bool_mode == bsa_pkg::MODE_BASIC
        |=> acc_we && done && acc_wdata == ~bsa_pkg::WORD_RESET)
        else $error("all-ones result wrong");

    comp_memory_a: assert property (
        fire_bool && bool_op == bsa_pkg::OP_COMPLEMENT_MEMORY_OPERAND
        && bool_mode == bsa_pkg::MODE_BASIC
        |=> acc_wdata == ~$past(mem_data))
        else $error("complement of memory wrong");

    nor_both_a: assert property (
        fire_bool && bool_op == bsa_pkg::OP_NOR_BOTH_OPERANDS && bool_mode == bsa_pkg::MODE_BASIC
        |=> acc_wdata == (~$past(acc_data) & ~$past(mem_data)))
        else $error("nor of both operands wrong");

    mem_mode_a: assert property (
        fire_bool && bool_mode == bsa_pkg::MODE_MEMORY
        |=> mem_we && !acc_we && mem_waddr == $past(ea))
        else $error("memory mode wrote the accumulator");

    jump_taken_a: assert property (
        fire_test && !test_on_mem && cond == bsa_pkg::CND_ALWAYS
        |=> pc_load && pc_value == $past(ea) && !skip)
        else $error("jump did not load pc");

    incr_skip_a: assert property (
        fire_test && test_on_mem && test_variant == bsa_pkg::TV_INCREMENT
        |=> mem_we && mem_wdata == $past(mem_data) + 36'h000000001)
        else $error("increment not written back");

    plain_test_a: assert property (
        fire_test && test_variant == bsa_pkg::TV_PLAIN |=> !acc_we && !mem_we)
        else $error("plain test modified a word");

    shift_done_a: assert property (
        fire_shift |=> busy [*1] ##[1:258] done)
        else $error("shift never finished");

    pair_sign_a: assert property (
        fin_arith_pair && pair_we |-> pair_wdata[bsa_pkg::SIGN_POS] == acc_wdata[bsa_pkg::SIGN_POS])
        else $error("pair sign not copied");

    ovf_source_a: assert property (
        overflow_set |-> done && $past(sh_kind) == bsa_pkg::SHK_ARITHMETIC)
        else $error("overflow outside arithmetic shift");

endmodule : bsa_alu

// ===== dv/bsa_alu_tb.sv
`timescale 1ns/100ps
module bsa_alu_tb;
    logic        clk = 1'b0, arst_n = 1'b0, start = 1'b0, shift_pair = 1'b0;
    logic        test_on_mem = 1'b0;
    logic [1:0]  group = 2'h0, bool_mode = 2'h0, shift_kind = 2'h0, test_variant = 2'h0;
    logic [3:0]  bool_op = 4'h0, acc_sel = 4'h0, acc_waddr, pair_waddr;
    logic [2:0]  cond = 3'h0;
    logic [17:0] ea = 18'h00000, mem_waddr, pc_value;
    logic [35:0] acc_data = 36'h0, pair_data = 36'h0, mem_data = 36'h0;
    logic [35:0] acc_wdata, pair_wdata, mem_wdata, v, e, m;
    logic        busy, done, overflow_set, acc_we, pair_we, mem_we, pc_load, skip;
    logic [5:0]  st;
    logic [72:0] r;
    logic [31:0] x, rs = 32'h4A60107F;
    logic [8:0]  cv;
    int          bad_count = 0, checks_done = 0, n, c;

    bsa_alu dut (.*);
    always #25 clk = ~clk;

    // ============================================================
    // helpers
    function automatic logic [31:0] xs();
        rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
        return rs;
    endfunction : xs
    function automatic logic [35:0] rw();
        logic [63:0] t;
        t = {xs(), xs()};
        return t[35:0];
    endfunction : rw
    function automatic logic [35:0] bf(input logic [3:0] op, input logic [35:0] a,
                                      input logic [35:0] b);
        // code bits from the top: both zero, accumulator only, memory only, both one
        return ({36{op[3]}} & ~a & ~b) | ({36{op[2]}} & a & ~b)
             | ({36{op[1]}} & ~a & b) | ({36{op[0]}} & a & b);
    endfunction : bf
    // single words ride in the top half; rotate copies the word so the top half stays true
    function automatic logic [72:0] shf(input logic [1:0] k, input int cn, input logic [71:0] w0);
        logic [71:0] w; logic [69:0] g; logic o;
        w = w0; o = 1'b0; g = {w[70:36], w[34:0]};
        for (int i = 0; i < (cn < 0 ? -cn : cn); i++)
            if (k == 2'h0) begin
                if (cn > 0) begin o |= w[71] ^ g[68]; g = {g[68:0], 1'b0}; end
                else g = {w[71], g[69:1]};
            end else if (k == 2'h1) w = cn > 0 ? {w[70:0], w[71]} : {w[0], w[71:1]};
            else w = cn > 0 ? {w[70:0], 1'b0} : {1'b0, w[71:1]};
        if (k == 2'h0) w = {w[71], g[69:35], w[71], g[34:0]};
        return {o, w};
    endfunction : shf
    // upper four codes are the negation of the lower four
    function automatic logic cm(input logic [2:0] cc, input logic [35:0] t);
        return cc[2] ^ ((cc[0] & t[35]) | (cc[1] & (t == 36'h0)));
    endfunction : cm
    task chk(input string nm, input logic [71:0] s, input logic [71:0] ex);
        checks_done++;
        if (s !== ex) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, ex, s);
        end
    endtask : chk
    task test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // strobes stand one cycle, so they are captured in the done cycle
    task go(input logic [1:0] g);
        group = g; start = 1'b1; n = 0;
        @(posedge clk); #5 start = 1'b0;
        while (done !== 1'b1) begin
            chk("busy", busy, 1'b1);
            if (++n > 300) begin bad_count++; test_done(); end
            @(posedge clk); #5;
        end
        chk("idle", busy, 1'b0);
        st = {acc_we, pair_we, mem_we, pc_load, skip, overflow_set};
        @(posedge clk); #5;
    endtask : go

    // ============================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        #5 arst_n = 1'b1;
        chk("rst", {done, acc_we, mem_we, pc_load, skip}, 5'h0);
        // reset in mid-shift must abandon the shift and clear busy, done and the write strobes
        ea = 18'h00064; group = 2'h1; start = 1'b1;
        @(posedge clk); #5 start = 1'b0;
        repeat (3) @(posedge clk);
        #5 arst_n = 1'b0;
        #5 chk("mrst", {busy, done, acc_we, pair_we, mem_we}, 5'h0);
        @(posedge clk); #5 arst_n = 1'b1;
        for (int j = 0; j < 32; j++) begin
            x = xs(); bool_op = 4'(j); bool_mode = 2'(j + j / 16);
            acc_data = rw(); mem_data = rw(); ea = x[17:0]; acc_sel = x[21:18];
            m = bool_mode == 2'h1 ? {18'h00000, ea} : mem_data;
            go(2'h0);
            chk("bwe", st[5:3], {bool_mode != 2'h2, 1'b0, bool_mode[1]});
            chk("badr", acc_waddr, acc_sel);
            chk("bres", bool_mode == 2'h2 ? mem_wdata : acc_wdata, bf(bool_op, acc_data, m));
            if (bool_mode[1]) chk("bmem", {mem_waddr, mem_wdata}, {ea, bf(bool_op, acc_data, m)});
        end
        for (int j = 0; j < 30; j++) begin
            x = xs(); shift_kind = 2'(j % 3); shift_pair = x[8];
            c = j < 3 ? -256 : j < 6 ? 0 : j < 9 ? 72 : int'($signed(x[6:0]));
            acc_sel = j % 5 == 0 ? 4'hF : x[15:12];
            cv = 9'(c); ea = {cv[8], x[24:16], cv[7:0]}; acc_data = rw(); pair_data = rw();
            r = shf(shift_kind, c, {acc_data, shift_pair ? pair_data :
                                   shift_kind == 2'h1 ? acc_data : 36'h0});
            go(2'h1);
            chk("count", n, (c < 0 ? -c : c) + 1);
            chk("hi", acc_wdata, r[71:36]);
            chk("ovf", st[0], r[72]);
            chk("swe", st[5:3], {1'b1, shift_pair && acc_sel != 4'hF,
                                 shift_pair && acc_sel == 4'hF});
            chk("aadr", acc_waddr, acc_sel);
            if (shift_pair) chk("padr", acc_sel == 4'hF ? mem_waddr : 18'(pair_waddr),
                                acc_sel == 4'hF ? 18'h00010 : 18'(acc_sel + 4'h1));
            if (shift_pair) chk("lo", acc_sel == 4'hF ? mem_wdata : pair_wdata, r[35:0]);
        end
        for (int j = 0; j < 48; j++) begin
            x = xs(); cond = 3'(j % 8); test_variant = 2'(j / 12); test_on_mem = x[4];
            v = x[9:8] == 2'h0 ? 36'h0 : x[9:8] == 2'h1 ? 36'hFFFFFFFFF : rw();
            acc_data = v; mem_data = v; ea = x[27:10];
            e = test_variant == 2'h1 ? v + 1 : test_variant == 2'h2 ? v - 1 : v;
            go(2'h2);
            chk("take", test_on_mem ? st[1] : st[2], cm(cond, e));
            chk("wr", test_on_mem ? st[3] : st[5], test_variant inside {2'h1, 2'h2});
            if (test_variant inside {2'h1, 2'h2})
                chk("val", test_on_mem ? mem_wdata : acc_wdata, e);
            if (!test_on_mem && st[2]) chk("pc", pc_value, ea);
        end
        test_done();
    end
endmodule : bsa_alu_tb
